/* common/daq_regs_pkg.sv */
/*
 * Register map, field positions, reset values and carrier types of the
 * acquisition board control block.
 * Assumes one 100 MHz clock shared with the host bus front end.
 */
`default_nettype none
package daq_regs_pkg;
   // byte offsets from the board base address
   localparam logic [4:0] OFS_DAC0 = 5'h08;
   localparam logic [4:0] OFS_CHAN_SCAN = 5'h0a;
   localparam logic [4:0] OFS_EEPROM_SER = 5'h0a;
   localparam logic [4:0] OFS_CAL_SER = 5'h0b;
   localparam logic [4:0] OFS_IRQ_EN = 5'h0c;
   localparam logic [4:0] OFS_FMT_SEL = 5'h0d;
   localparam logic [4:0] OFS_DAC1 = 5'h0e;
   localparam logic [4:0] OFS_DIO_LO = 5'h10;
   localparam logic [4:0] OFS_DIO_HI = 5'h11;
   localparam logic [4:0] OFS_DIO_RST = 5'h19;
   // serial bit-bang byte layout
   localparam int SER_DATA_POS = 7;
   localparam int SER_CLK_POS = 0;
   // channel readback layout
   localparam int RB_UNDER_POS = 6;
   localparam int RB_END_POS = 4;
   // command codes
   localparam logic [7:0] IRQ_EN_CODE = 8'h10;
   localparam logic [7:0] IRQ_DIS_CODE = 8'h00;
   localparam logic [7:0] FMT_TWOS_CODE = 8'h01;
   localparam logic [7:0] FMT_OFFSET_CODE = 8'h00;
   localparam logic [15:0] DAC_SYNC_CMD = 16'h8000;
   // calibration potentiometer load: 2 address bits then 8 value bits
   localparam logic [3:0] CAL_SHIFT_BITS = 4'ha;
   localparam logic [1:0] POT_AD_OFFSET = 2'h0;
   localparam logic [1:0] POT_AD_GAIN = 2'h1;
   localparam logic [1:0] POT_DAC0_GAIN = 2'h2;
   localparam logic [1:0] POT_DAC1_GAIN = 2'h3;
   // values after reset
   localparam logic [7:0] POT_RESET = 8'h80;
   localparam logic [11:0] DAC_RESET = 12'h000;
   localparam logic UNDER_RESET = 1'b1;
   localparam logic [7:0] DIO_OE_OFF = 8'hff;
   localparam int DAC_W = 12;

   // one host i/o cycle, one clock wide
   typedef struct packed {
      logic [4:0] addr;
      logic wr;
      logic rd;
      logic word;
      logic [15:0] wdata;
   } io_req_s;

   // converter state seen by the readback register
   typedef struct packed {
      logic [3:0] chan;
      logic [3:0] scan_end;
      logic scan_active;
      logic conv_done;
      logic single_ended;
   } scan_state_s;

   typedef logic [3:0][7:0] pot_bank_t;
endpackage
`default_nettype wire

/* rtl/daq_board_control_registers.sv */
/*
 * Host-visible control registers of the acquisition board: eeprom and
 * potentiometer bit-bang ports, channel/scan readback, irq enable, result
 * format, dac words and two bytes of digital i/o.
 * Assumes host strobes and converter state are synchronous to core_clk_i;
 * eeprom data and digital pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
// Operation
// (RL1) host reads eeprom word: nine writes, sixteen reads, one closing write
// (RL2) every eeprom transaction opens with start byte 81
// (RL3) read opcode is one then zero on bit 7, bit 0 high
// (RL4) writes four to nine carry six address bits, msb first
// (RL5) each of sixteen reads returns one eeprom data bit on bit 7
// (RL6) host closes eeprom read with byte 00
// (RL7) low four readback bits show the channel being converted
// (RL8) top channel bit valid in single-ended mode only
// (RL9) scan flag low at next-to-last channel, high after final conversion
// (RL10) scan end flag zero when channel equals scan end address
// (RL11) four eight-bit potentiometer settings held, two-bit select
// (RL12) select 00 offset, 01 gain, 10 dac0 gain, 11 dac1 gain
// (RL13) host sends two address bits then eight value bits, msb first
// (RL14) host ends potentiometer load with bit 7 low, bit 0 high
// (RL15) irq on fifo half full when enabled; full fifo pauses conversions
// (RL16) irq enable register: 10 enables, 00 disables
// (RL17) offset binary default; 01 selects twos complement, 00 returns
// (RL18) second dac loaded like first; joint update only via first dac
// (RL19) digital byte in input mode reads its pins
// (RL20) writing a digital byte makes it output and drives value
// (RL21) output-mode digital byte reads back last written value
// (RL22) write to digital reset address returns all sixteen to input
// (RL23) dac code is low twelve bits of the word
// (RL24) simultaneous mode: 8000 to first dac updates both outputs
// (RL25) serial port write drives data from bit 7, clock from bit 0
module daq_board_control_registers (
   input wire logic core_clk_i, // 100 MHz clock
   input wire logic rst_n_i, // async reset, active low
   input wire daq_regs_pkg::io_req_s io_req_i, // host i/o cycle
   output logic [7:0] io_rdata_o, // read data, registered
   output logic io_rvalid_o, // read data valid pulse
   input wire daq_regs_pkg::scan_state_s scan_i, // converter scan state
   input wire logic fifo_half_i, // fifo at least half full
   input wire logic fifo_full_i, // fifo full
   output logic irq_o, // interrupt request
   output logic adc_pause_o, // hold further conversions
   output logic twos_comp_o, // result format select
   input wire logic dac_simul_i, // dac simultaneous mode
   output logic [11:0] dac0_o, // first dac code
   output logic [11:0] dac1_o, // second dac code
   output logic ee_data_o, // eeprom serial data out
   output logic ee_clk_o, // eeprom serial clock
   input wire logic ee_data_i, // eeprom serial data in, async
   output logic cal_data_o, // potentiometer serial data
   output logic cal_clk_o, // potentiometer serial clock
   output var daq_regs_pkg::pot_bank_t pot_o, // held potentiometer settings
   input wire logic [15:0] dio_i, // digital pin levels, async
   output logic [15:0] dio_o, // digital pin drive values
   output logic [15:0] dio_oe_n_o // digital pin enables, low drives
);
   import daq_regs_pkg::*;

   logic wr_ee, wr_cal, wr_irq, wr_fmt, wr_dac0, wr_dac1, wr_rst;
   logic [1:0] wr_dio;
   logic ee_meta_q, ee_sync_q;
   logic [15:0] dio_meta_q, dio_sync_q;
   logic [1:0] dio_out_q;
   logic [15:0] dio_val_q;
   logic irq_en_q, twos_q, under_q;
   logic [11:0] dac0_hold_q, dac1_hold_q, dac0_q, dac1_q;
   logic [3:0] cal_cnt_q;
   logic [9:0] cal_shift_q;
   pot_bank_t pot_q;
   logic [7:0] rdata_d, rdata_q;
   logic rvalid_q;
   logic [3:0] last_chan_q;

   // write decode, one strobe per register
   assign wr_ee = io_req_i.wr && io_req_i.addr == OFS_EEPROM_SER;
   assign wr_cal = io_req_i.wr && io_req_i.addr == OFS_CAL_SER;
   assign wr_irq = io_req_i.wr && io_req_i.addr == OFS_IRQ_EN;
   assign wr_fmt = io_req_i.wr && io_req_i.addr == OFS_FMT_SEL;
   assign wr_dac0 = io_req_i.wr && io_req_i.word && io_req_i.addr == OFS_DAC0;
   assign wr_dac1 = io_req_i.wr && io_req_i.word && io_req_i.addr == OFS_DAC1;
   assign wr_rst = io_req_i.wr && io_req_i.addr == OFS_DIO_RST;
   assign wr_dio[0] = io_req_i.wr && io_req_i.addr == OFS_DIO_LO;
   assign wr_dio[1] = io_req_i.wr && io_req_i.addr == OFS_DIO_HI;

   // two-stage synchronisers for the asynchronous inputs
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ee_meta_q <= 1'b0;
         ee_sync_q <= 1'b0;
         dio_meta_q <= 16'h0000;
         dio_sync_q <= 16'h0000;
      end
      else
      begin
         ee_meta_q <= ee_data_i;
         ee_sync_q <= ee_meta_q;
         dio_meta_q <= dio_i;
         dio_sync_q <= dio_meta_q;
      end
   end

   // eeprom bit-bang port: pins follow the last byte written
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ee_data_o <= 1'b0;
         ee_clk_o <= 1'b0;
      end
      else if (wr_ee)
      begin
         ee_data_o <= io_req_i.wdata[SER_DATA_POS]; // [RL25]
         ee_clk_o <= io_req_i.wdata[SER_CLK_POS]; // [RL25]
      end
   end

   // potentiometer port: pins follow the byte, bits shift into a holder
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cal_data_o <= 1'b0;
         cal_clk_o <= 1'b0;
         cal_cnt_q <= 4'h0;
         cal_shift_q <= 10'h000;
      end
      else if (wr_cal)
      begin
         cal_data_o <= io_req_i.wdata[SER_DATA_POS]; // [RL25]
         cal_clk_o <= io_req_i.wdata[SER_CLK_POS]; // [RL25]
         if (cal_cnt_q < CAL_SHIFT_BITS)
         begin
            // address bits first, then value, msb first
            cal_shift_q <= {cal_shift_q[8:0], io_req_i.wdata[SER_DATA_POS]}; // [RL13]
            cal_cnt_q <= cal_cnt_q + 4'h1;
         end
         else
         begin
            cal_cnt_q <= 4'h0; // closing byte ends the load [RL14]
         end
      end
   end

   // settings bank, committed by the closing byte; index is the 2-bit select
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pot_q <= {4{POT_RESET}};
      end
      else if (wr_cal && cal_cnt_q == CAL_SHIFT_BITS)
      begin
         pot_q[cal_shift_q[9:8]] <= cal_shift_q[7:0]; // [RL11] [RL12]
      end
   end
   assign pot_o = pot_q;

   // interrupt enable and result format registers
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         irq_en_q <= 1'b0;
         twos_q <= 1'b0; // offset binary after reset [RL17]
      end
      else
      begin
         if (wr_irq && io_req_i.wdata[7:0] == IRQ_EN_CODE)
            irq_en_q <= 1'b1; // [RL16]
         else if (wr_irq && io_req_i.wdata[7:0] == IRQ_DIS_CODE)
            irq_en_q <= 1'b0; // [RL16]
         if (wr_fmt && io_req_i.wdata[7:0] == FMT_TWOS_CODE)
            twos_q <= 1'b1; // [RL17]
         else if (wr_fmt && io_req_i.wdata[7:0] == FMT_OFFSET_CODE)
            twos_q <= 1'b0; // [RL17]
      end
   end
   assign irq_o = irq_en_q && fifo_half_i; // [RL15]
   assign adc_pause_o = fifo_full_i; // [RL15]
   assign twos_comp_o = twos_q;

   // dac words: direct in automatic mode, held for a joint update otherwise
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dac0_hold_q <= DAC_RESET;
         dac1_hold_q <= DAC_RESET;
         dac0_q <= DAC_RESET;
         dac1_q <= DAC_RESET;
      end
      else
      begin
         if (wr_dac0 && dac_simul_i && io_req_i.wdata == DAC_SYNC_CMD)
         begin
            dac0_q <= dac0_hold_q; // [RL24]
            dac1_q <= dac1_hold_q; // [RL24] [RL18]
         end
         else if (wr_dac0)
         begin
            dac0_hold_q <= io_req_i.wdata[DAC_W-1:0]; // [RL23]
            if (!dac_simul_i)
               dac0_q <= io_req_i.wdata[DAC_W-1:0];
         end
         if (wr_dac1)
         begin
            dac1_hold_q <= io_req_i.wdata[DAC_W-1:0]; // [RL18] [RL23]
            if (!dac_simul_i)
               dac1_q <= io_req_i.wdata[DAC_W-1:0];
         end
      end
   end
   assign dac0_o = dac0_q;
   assign dac1_o = dac1_q;

   // digital i/o: a write turns its byte to output, the reset address undoes it
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dio_out_q <= 2'b00;
         dio_val_q <= 16'h0000;
      end
      else
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (wr_dio[b])
            begin
               dio_out_q[b] <= 1'b1; // [RL20]
               dio_val_q[b*8 +: 8] <= io_req_i.wdata[7:0]; // [RL20]
            end
         end
         if (wr_rst)
            dio_out_q <= 2'b00; // [RL22]
      end
   end
   assign dio_o = dio_val_q;
   assign dio_oe_n_o = {{8{!dio_out_q[1]}}, {8{!dio_out_q[0]}}};

   // scan position flag: low at next-to-last, high once last is converted
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         under_q <= UNDER_RESET;
      else if (scan_i.conv_done && scan_i.chan == scan_i.scan_end)
         under_q <= 1'b1; // [RL9]
      else if (scan_i.scan_active && scan_i.chan == scan_i.scan_end - 4'h1)
         under_q <= 1'b0; // [RL9]
   end

   // read mux; unmapped addresses answer zero
   always_comb
   begin
      rdata_d = 8'h00;
      case (io_req_i.addr)
         OFS_CHAN_SCAN:
         begin
            rdata_d[SER_DATA_POS] = ee_sync_q; // [RL5]
            rdata_d[RB_UNDER_POS] = under_q; // [RL9]
            rdata_d[RB_END_POS] = scan_i.chan != scan_i.scan_end; // [RL10]
            rdata_d[2:0] = scan_i.chan[2:0]; // [RL7]
            rdata_d[3] = scan_i.single_ended & scan_i.chan[3]; // [RL8]
         end
         OFS_DIO_LO:
            rdata_d = dio_out_q[0] ? dio_val_q[7:0] : dio_sync_q[7:0]; // [RL19] [RL21]
         OFS_DIO_HI:
            rdata_d = dio_out_q[1] ? dio_val_q[15:8] : dio_sync_q[15:8]; // [RL19] [RL21]
         default:
            rdata_d = 8'h00;
      endcase
   end

   // read answer registered one cycle after the strobe
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= io_req_i.rd;
         if (io_req_i.rd)
            rdata_q <= rdata_d;
      end
   end
   assign io_rdata_o = rdata_q;
   assign io_rvalid_o = rvalid_q;

   // helper for checks: channel seen at the last read strobe
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         last_chan_q <= 4'h0;
      else if (io_req_i.rd)
         last_chan_q <= scan_i.chan;
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   eeprom_bit_read_a: assert property (io_req_i.rd && io_req_i.addr == OFS_CHAN_SCAN // [RL5]
      |=> io_rvalid_o && io_rdata_o[7] == $past(ee_sync_q))
      else $error("eeprom bit not returned on bit 7");
   chan_readback_a: assert property (io_req_i.rd && io_req_i.addr == OFS_CHAN_SCAN // [RL7]
      |=> io_rdata_o[2:0] == last_chan_q[2:0])
      else $error("channel readback wrong");
   scan_end_flag_a: assert property (io_req_i.rd && io_req_i.addr == OFS_CHAN_SCAN // [RL10]
      && scan_i.chan == scan_i.scan_end |=> !io_rdata_o[4])
      else $error("scan end flag not zero at end address");
   under_flag_a: assert property (scan_i.scan_active && !scan_i.conv_done // [RL9]
      && scan_i.chan == scan_i.scan_end - 4'h1 |=> !under_q)
      else $error("scan position flag not low at next-to-last");
   pot_commit_a: assert property (wr_cal && cal_cnt_q == CAL_SHIFT_BITS // [RL11]
      && cal_shift_q[9:8] == POT_AD_GAIN |=> pot_o[1] == $past(cal_shift_q[7:0]))
      else $error("potentiometer value not committed");
   irq_enable_a: assert property (wr_irq && io_req_i.wdata[7:0] == IRQ_EN_CODE // [RL16]
      ##1 fifo_half_i |-> irq_o)
      else $error("irq missing after enable");
   format_sel_a: assert property (wr_fmt && io_req_i.wdata[7:0] == FMT_TWOS_CODE // [RL17]
      |=> twos_comp_o)
      else $error("twos complement not selected");
   dio_drive_a: assert property (wr_dio[0] && !wr_rst // [RL20]
      |=> dio_oe_n_o[7:0] == 8'h00 && dio_o[7:0] == $past(io_req_i.wdata[7:0]))
      else $error("digital byte not driven");
   dio_reset_a: assert property (wr_rst |=> dio_oe_n_o == 16'hffff) // [RL22]
      else $error("digital reset left pins driven");
   dac_sync_a: assert property (wr_dac0 && dac_simul_i && io_req_i.wdata == DAC_SYNC_CMD // [RL24]
      |=> dac0_o == $past(dac0_hold_q) && dac1_o == $past(dac1_hold_q))
      else $error("joint dac update failed");
   ser_pins_a: assert property (wr_ee |=> ee_data_o == $past(io_req_i.wdata[7]) // [RL25]
      && ee_clk_o == $past(io_req_i.wdata[0]))
      else $error("eeprom pins do not follow write");

   pot_load_c: cover property (wr_cal && cal_cnt_q == CAL_SHIFT_BITS);
   dac_sync_c: cover property (wr_dac0 && dac_simul_i && io_req_i.wdata == DAC_SYNC_CMD);
   dio_cycle_c: cover property (wr_dio[1] ##[1:20] wr_rst);
endmodule
`default_nettype wire

/* testbench/ee_model.sv */
/*
 * serial calibration store standing at the far side of the eeprom port.
 * assumes step_i pulses once after every host access to the serial port.
 */
`timescale 1ns/1ns
`default_nettype none
module ee_model (
   input wire logic clk_i, // bench clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic step_i, // one pulse per host access
   input wire logic ser_clk_i, // serial clock from the board
   input wire logic ser_data_i, // serial data from the board
   output logic ser_data_o // data bit back to the board
);
   logic [8:0] sh_q;
   logic [3:0] cnt_q;
   logic rd_q;
   logic tog_q;
   logic [15:0] word_q;
   // take start, opcode and address, then hand out one bit per read
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 4'h0;
         rd_q <= 1'b0;
      end
      else if (step_i && !ser_clk_i)
      begin
         cnt_q <= 4'h0; // closing byte ends the transfer
         rd_q <= 1'b0;
      end
      else if (step_i && !rd_q)
      begin
         sh_q <= {sh_q[7:0], ser_data_i}; // address msb first
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == 4'h8)
         begin
            rd_q <= sh_q[7] & sh_q[6] & !sh_q[5]; // start, then opcode 1,0
            word_q <= {sh_q[4:0], ser_data_i, ~sh_q[4:0], ~ser_data_i, 4'h9};
         end
      end
      else if (step_i)
         word_q <= {word_q[14:0], 1'b0}; // next bit after each read
   end
   // idle line toggles so a stale level never passes for data
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tog_q <= 1'b0;
      else
         tog_q <= !tog_q;
   end
   assign ser_data_o = rd_q ? word_q[15] : tog_q;
endmodule
`default_nettype wire

/* testbench/daq_board_control_registers_tb.sv */
/*
 * self-checking bench of the board control registers with random stimulus.
 * assumes the design package and the eeprom stand-in are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module daq_board_control_registers_tb;
   import daq_regs_pkg::*;
   logic clk, rst_n, rvalid, fifo_half, fifo_full, irq, pause, twos, simul;
   logic ee_do, ee_ck, ee_di, cal_d, cal_c, step;
   io_req_s req;
   scan_state_s scan;
   logic [7:0] rdata, v;
   logic [11:0] dac0, dac1, a, b;
   pot_bank_t pot;
   logic [15:0] dio_w, dio_o, oe_n, ext;
   logic [7:0] pexp [4];
   logic [31:0] rng;
   int err_total, tests_run;
   // pin level from whichever party enables its driver
   assign dio_w = (oe_n & ext) | (~oe_n & dio_o);
   daq_board_control_registers dut (
      .core_clk_i(clk), .rst_n_i(rst_n), .io_req_i(req), .io_rdata_o(rdata),
      .io_rvalid_o(rvalid), .scan_i(scan), .fifo_half_i(fifo_half),
      .fifo_full_i(fifo_full), .irq_o(irq), .adc_pause_o(pause), .twos_comp_o(twos),
      .dac_simul_i(simul), .dac0_o(dac0), .dac1_o(dac1), .ee_data_o(ee_do),
      .ee_clk_o(ee_ck), .ee_data_i(ee_di), .cal_data_o(cal_d), .cal_clk_o(cal_c),
      .pot_o(pot), .dio_i(dio_w), .dio_o(dio_o), .dio_oe_n_o(oe_n)
   );
   ee_model em (
      .clk_i(clk), .rst_n_i(rst_n), .step_i(step), .ser_clk_i(ee_ck),
      .ser_data_i(ee_do), .ser_data_o(ee_di)
   );
   // free-running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] ad, input logic [15:0] d, input logic w);
      @(posedge clk);
      req <= '{addr:ad, wr:1'b1, rd:1'b0, word:w, wdata:d};
      @(posedge clk);
      req.wr <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [4:0] ad, output logic [7:0] r);
      int n;
      @(posedge clk);
      req <= '{addr:ad, wr:1'b0, rd:1'b1, word:1'b0, wdata:16'h0000};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      n = 0;
      while (rvalid !== 1'b1 && n < 4)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 4)
      begin
         err_total++;
         end_of_test();
      end
      r = rdata;
   endtask
   task automatic tick;
      @(posedge clk);
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic ee_wr(input logic [7:0] d);
      wr(OFS_EEPROM_SER, {8'h00, d}, 1'b0);
      chk("eeprom pins", {ee_do, ee_ck}, {d[7], d[0]});
      tick();
   endtask
   task automatic ee_read(input logic [5:0] ad);
      logic [15:0] e;
      ee_wr(8'h81);
      ee_wr(8'h81);
      ee_wr(8'h01);
      for (int i = 5; i >= 0; i--)
         ee_wr({ad[i], 6'h00, 1'b1});
      e = {ad, ~ad, 4'h9};
      for (int i = 15; i >= 0; i--)
      begin
         rd(OFS_EEPROM_SER, v);
         chk("eeprom bit", e[i], v[7]);
         tick();
      end
      ee_wr(8'h00);
   endtask
   task automatic pot_load(input logic [1:0] k, input logic [7:0] d);
      logic [9:0] s;
      s = {k, d};
      for (int i = 9; i >= 0; i--)
      begin
         wr(OFS_CAL_SER, {8'h00, s[i], 6'h00, 1'b1}, 1'b0);
         chk("cal pins", {cal_d, cal_c}, {s[i], 1'b1});
      end
      wr(OFS_CAL_SER, 16'h0001, 1'b0);
      pexp[k] = d;
      @(posedge clk);
      #1;
      for (int j = 0; j < 4; j++)
         chk("pot", pexp[j], pot[j]);
   endtask
   task automatic rb(input logic u);
      rd(OFS_CHAN_SCAN, v);
      chk("readback", {u, 1'b0, scan.chan != scan.scan_end,
          scan.single_ended & scan.chan[3], scan.chan[2:0]}, v[6:0]);
   endtask
   // hang guard
   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      end_of_test();
   end
   // main sequence
   initial
   begin
      rng = 32'h6297;
      err_total = 0;
      tests_run = 0;
      rst_n = 1'b0;
      req = '0;
      scan = '0;
      {fifo_half, fifo_full, simul, step} = 4'h0;
      ext = 16'h5a3c;
      pexp = '{8'h80, 8'h80, 8'h80, 8'h80};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("pot reset", {pot[0], pot[1]}, 16'h8080);
      chk("pot reset", {pot[2], pot[3]}, 16'h8080);
      chk("oe reset", 16'hffff, oe_n);
      chk("format reset", 16'h0000, twos);
      repeat (6)
      begin
         rng = xs(rng);
         scan <= '{chan:rng[3:0], scan_end:rng[7:4], scan_active:1'b0, conv_done:1'b0,
                   single_ended:rng[8]};
         rb(1'b1);
      end
      scan <= '{chan:4'h3, scan_end:4'h9, scan_active:1'b1, conv_done:1'b0, single_ended:1'b1};
      rb(1'b1);
      scan.chan <= 4'h8;
      rb(1'b0);
      scan.chan <= 4'h9;
      rb(1'b0);
      scan.conv_done <= 1'b1;
      @(posedge clk);
      scan.conv_done <= 1'b0;
      scan.scan_active <= 1'b0;
      rb(1'b1);
      rd(5'h1f, v);
      chk("unmapped", 16'h0000, v);
      fifo_half <= 1'b1;
      fifo_full <= 1'b1;
      wr(OFS_IRQ_EN, 16'h0010, 1'b0);
      chk("irq", 16'h0001, irq);
      chk("pause", 16'h0001, pause);
      wr(OFS_IRQ_EN, 16'h0033, 1'b0);
      chk("irq", 16'h0001, irq);
      wr(OFS_IRQ_EN, 16'h0000, 1'b0);
      chk("irq", 16'h0000, irq);
      fifo_full <= 1'b0;
      wr(OFS_FMT_SEL, 16'h0001, 1'b0);
      chk("format", 16'h0001, twos);
      chk("pause", 16'h0000, pause);
      wr(OFS_FMT_SEL, 16'h0000, 1'b0);
      chk("format", 16'h0000, twos);
      rng = xs(rng);
      a = rng[11:0];
      b = rng[27:16];
      wr(OFS_DAC0, {4'h0, a}, 1'b1);
      wr(OFS_DAC1, {4'h0, b}, 1'b1);
      chk("dac0", a, dac0);
      chk("dac1", b, dac1);
      simul <= 1'b1;
      wr(OFS_DAC0, {4'h0, ~a}, 1'b1);
      wr(OFS_DAC1, {4'h0, ~b}, 1'b1);
      chk("dac1 held", b, dac1);
      chk("dac0 held", a, dac0);
      wr(OFS_DAC0, 16'h8000, 1'b1);
      chk("dac0", {4'h0, ~a}, dac0);
      chk("dac1", {4'h0, ~b}, dac1);
      simul <= 1'b0;
      rd(OFS_DIO_LO, v);
      chk("dio lo", ext[7:0], v);
      rd(OFS_DIO_HI, v);
      chk("dio hi", ext[15:8], v);
      rng = xs(rng);
      wr(OFS_DIO_LO, {8'h00, rng[7:0]}, 1'b0);
      chk("oe", 16'hff00, oe_n);
      chk("dio drive", rng[7:0], dio_o[7:0]);
      ext <= rng[31:16];
      repeat (3) @(posedge clk);
      rd(OFS_DIO_LO, v);
      chk("dio lo", rng[7:0], v);
      rd(OFS_DIO_HI, v);
      chk("dio hi", rng[31:24], v);
      wr(OFS_DIO_HI, 16'h00a5, 1'b0);
      chk("oe", 16'h0000, oe_n);
      wr(OFS_DIO_RST, 16'h0000, 1'b0);
      chk("oe", 16'hffff, oe_n);
      repeat (3) @(posedge clk);
      rd(OFS_DIO_LO, v);
      chk("dio lo", rng[23:16], v);
      ee_read(6'h04);
      ee_read(6'h3f);
      rng = xs(rng);
      ee_read(rng[5:0]);
      pot_load(2'h1, 8'h4f);
      pot_load(2'h0, 8'hff);
      for (int k = 0; k < 4; k++)
      begin
         rng = xs(rng);
         pot_load(k[1:0], rng[7:0]);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
